// [core/sei_eeprom.sv]
// Serial EEPROM pin interface: serial shifter on the link clock, array,
// status, protection and the self-timed write on the system clock.
// Assumes a host drives cs_n, sck and si; so and so_oe feed a tri-state pad.
`timescale 1ns/1ns
`default_nettype none
module sei_eeprom #(
  parameter int WRITE_CYCLES = sei_pkg::WRITE_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic wp_n,
  input  wire logic hold_n,
  output logic      so,
  output logic      so_oe,
  output logic      write_busy
);

  // System clock domain declarations.
  logic                       link_rst_r;     // Resets link-side state.
  logic                       cs_s;           // Synchronised chip select.
  logic                       wp_s;           // Synchronised write protect.
  logic                       tog_s;          // Synchronised frame toggle.
  logic                       cs_q_r;         // Chip select one cycle back.
  logic                       wp_q_r;         // Write protect one cycle back.
  logic                       armed_r;        // Deselect seen since reset.
  logic                       frame_ok_r;     // Frame began while armed.
  logic                       wp_fell_r;      // Protect fell inside frame.
  logic                       last_tog_r;     // Toggle of last frame served.
  logic                       pen_r;          // Protect pin enable bit.
  logic [1:0]                 bp_r;           // Block protect setting.
  logic                       wel_r;          // Write enable latch.
  sei_pkg::sei_wkind_t        pend_kind_r;    // Write waiting on the timer.
  logic [sei_pkg::ADDR_W-1:0] pend_addr_r;    // Its address.
  logic [sei_pkg::DATA_W-1:0] pend_data_r;    // Its data.
  logic                       wt_done;        // Timer finished pulse.
  logic [7:0]                 status_w;       // Status byte as read back.

  // The array; written only here, read by the link side.
  logic [sei_pkg::DATA_W-1:0] mem [sei_pkg::MEM_DEPTH];

  // Link clock domain declarations.
  logic                       frame_rst;      // Ends all per-frame state.
  logic [5:0]                 bit_cnt_r;      // Rising edges seen in frame.
  logic [6:0]                 shift_r;        // Partial incoming byte.
  logic [sei_pkg::ADDR_W-1:0] rd_addr_r;      // Read pointer.
  logic [7:0]                 op_r;           // Held opcode.
  logic [sei_pkg::ADDR_W-1:0] addr_r;         // Held address.
  logic [7:0]                 data_r;         // Held data byte.
  logic [2:0]                 len_r;          // Held completed-byte count.
  logic                       frame_tog_r;    // Flips once per clocked frame.
  logic                       hold_s;         // Synchronised hold, high idle.
  logic                       armed_link_r;   // Deselect seen, link side.
  logic [7:0]                 status_s;       // Status byte on link side.

  // Crossings.

  // One clock after rst_n falls the link side is forced into reset too.
  always_ff @(posedge clock)
  begin
    link_rst_r <= !rst_n;
  end

  // Chip select resets high, so a select held through power-up shows no
  // deselect edge; only a rise seen after reset arms the device.
  sei_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h6)
  ) u_sync_sys (
    .clk  (clock),
    .arst (link_rst_r),
    .din  ({cs_n, wp_n, frame_tog_r}),
    .dout ({cs_s, wp_s, tog_s})
  );

  // Hold and status only move while sck runs, which is the only time the
  // link side reads them; status changes rarely, so per-bit crossing is safe.
  sei_sync #(
    .WIDTH   (9),
    .RST_VAL (9'h100)
  ) u_sync_link (
    .clk  (sck),
    .arst (link_rst_r),
    .din  ({hold_n, status_w}),
    .dout ({hold_s, status_s})
  );

  // The link side arms on the first deselect edge after reset. A sync on
  // sck would lose the first bits of the first frame, and this flag only
  // moves while chip select is high, so no sck edge sees it change.
  always_ff @(posedge cs_n or posedge link_rst_r)
  begin
    if (link_rst_r)
    begin
      armed_link_r <= 1'b0;
    end
    else
    begin
      armed_link_r <= 1'b1;
    end
  end

  // System clock side: frame tracking, command execution, timing.
  wire cs_rise   = cs_s && !cs_q_r;
  wire cs_fall   = !cs_s && cs_q_r;
  wire wp_fall   = !wp_s && wp_q_r;

  // A frame is served once, only if sck really ran in it.
  wire new_frame = tog_s != last_tog_r;
  wire exec      = cs_rise && frame_ok_r && new_frame && !write_busy;

  // Held fields are stable here: sck is halted while chip select is high.
  wire is_wren   = op_r == sei_pkg::OP_WREN  && len_r >= sei_pkg::LEN_OP;
  wire is_wrdi   = op_r == sei_pkg::OP_WRDI  && len_r >= sei_pkg::LEN_OP;
  wire is_wrsr   = op_r == sei_pkg::OP_WRSR  && len_r >= sei_pkg::LEN_WRSR;
  wire is_write  = op_r == sei_pkg::OP_WRITE && len_r >= sei_pkg::LEN_WRITE;

  // Status writes are refused only when the enable bit is set and the pin
  // is low now or fell during the frame; a pin high throughout the frame never blocks.
  wire st_block  = pen_r && (!wp_s || wp_fell_r);

  // Address falls in the protected block chosen by the status bits.
  wire in_block  = (bp_r == sei_pkg::BP_QUART && addr_r >= sei_pkg::QUART_BASE)
                || (bp_r == sei_pkg::BP_HALF  && addr_r >= sei_pkg::HALF_BASE)
                || (bp_r == 2'b11);

  wire st_go     = exec && is_wrsr && wel_r && !st_block;
  wire arr_go    = exec && is_write && wel_r && !in_block;

  // Status byte assembled from its fields; unused bits read zero.
  assign status_w = (8'(pen_r) << sei_pkg::ST_PEN)
                  | (8'(bp_r) << sei_pkg::ST_BP_LO)
                  | (8'(wel_r) << sei_pkg::ST_WEL)
                  | (8'(write_busy) << sei_pkg::ST_BUSY);

  // Edge history and power-up arming.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cs_q_r     <= 1'b1;
      wp_q_r     <= 1'b1;
      armed_r    <= 1'b0;
      frame_ok_r <= 1'b0;
      last_tog_r <= 1'b0;
    end
    else
    begin
      cs_q_r  <= cs_s;
      wp_q_r  <= wp_s;
      armed_r <= armed_r || cs_rise;
      if (cs_fall)
      begin
        frame_ok_r <= armed_r;
      end
      if (cs_rise)
      begin
        last_tog_r <= tog_s;
      end
    end
  end

  // Protect fall inside a frame; a fall in the clearing cycle still sets.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wp_fell_r <= 1'b0;
    end
    else
    begin
      wp_fell_r <= (wp_fall && !cs_s) || (wp_fell_r && !cs_fall);
    end
  end

  // Write enable latch, status fields and the pending write.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wel_r       <= 1'b0;
      pen_r       <= sei_pkg::PEN_RST;
      bp_r        <= sei_pkg::BP_RST;
      pend_kind_r <= sei_pkg::SEI_WK_NONE;
      pend_addr_r <= '0;
      pend_data_r <= '0;
    end
    else if (wt_done)
    begin
      // Commit happens whatever the pin does now.
      wel_r       <= 1'b0;
      pend_kind_r <= sei_pkg::SEI_WK_NONE;
      if (pend_kind_r == sei_pkg::SEI_WK_STATUS)
      begin
        pen_r <= pend_data_r[sei_pkg::ST_PEN];
        bp_r  <= pend_data_r[sei_pkg::ST_BP_LO +: 2];
      end
    end
    else if (exec)
    begin
      if (is_wren)
      begin
        wel_r <= 1'b1;
      end
      else if (is_wrdi)
      begin
        wel_r <= 1'b0;
      end
      else if (st_go)
      begin
        pend_kind_r <= sei_pkg::SEI_WK_STATUS;
        pend_data_r <= data_r;
      end
      else if (arr_go)
      begin
        pend_kind_r <= sei_pkg::SEI_WK_ARRAY;
        pend_addr_r <= addr_r;
        pend_data_r <= data_r;
      end
    end
  end

  // The array byte lands when the write cycle ends.
  always_ff @(posedge clock)
  begin
    if (wt_done && pend_kind_r == sei_pkg::SEI_WK_ARRAY)
    begin
      mem[pend_addr_r] <= pend_data_r;
    end
  end

  // Write cycle runs from its own counter, no sck needed.
  sei_wtimer #(
    .CYCLES (WRITE_CYCLES)
  ) u_wtimer (
    .clock (clock),
    .rst_n (rst_n),
    .start (st_go || arr_go),
    .busy  (write_busy),
    .done  (wt_done)
  );

  // Link side: shifting in on rising sck, out on falling sck.

  // Deselect clears the frame at once, even with sck stopped.
  assign frame_rst = cs_n || link_rst_r;

  // Bits count only when armed and not on hold.
  wire       active   = armed_link_r && hold_s;
  wire [7:0] byte_in  = {shift_r, si};
  wire       byte_end = bit_cnt_r[2:0] == 3'h7;
  wire       busy_s   = status_s[sei_pkg::ST_BUSY];

  // Data phase wraps so a long read never runs the counter over.
  wire [5:0] cnt_nxt  = (bit_cnt_r == sei_pkg::CNT_DATA_END) ?
                        sei_pkg::CNT_DATA0 : bit_cnt_r + 6'h01;

  // Byte to send: status for a status read, else the array byte.
  wire [7:0] tx_byte  = (op_r == sei_pkg::OP_RDSR) ? status_s : mem[rd_addr_r];

  // Array reads are refused while a write cycle runs; status reads are not.
  wire       out_ph   = (op_r == sei_pkg::OP_RDSR && bit_cnt_r >= sei_pkg::CNT_RDSR0)
                     || (op_r == sei_pkg::OP_READ && bit_cnt_r >= sei_pkg::CNT_DATA0
                         && !busy_s);

  // Per-frame shifter and read pointer. Only rising edges sample si, so
  // the idle level of sck, low or high, makes no difference.
  always_ff @(posedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      bit_cnt_r <= '0;
      shift_r   <= '0;
      rd_addr_r <= '0;
    end
    else if (active)
    begin
      bit_cnt_r <= cnt_nxt;
      shift_r   <= byte_in[6:0];
      if (bit_cnt_r == sei_pkg::CNT_ADL_END)
      begin
        rd_addr_r <= {addr_r[7:0], byte_in};
      end
      else if (bit_cnt_r == sei_pkg::CNT_DATA_END)
      begin
        rd_addr_r <= rd_addr_r + 16'h0001;
      end
    end
  end

  // Held command fields outlive the frame for the system side to execute.
  always_ff @(posedge sck or posedge link_rst_r)
  begin
    if (link_rst_r)
    begin
      op_r        <= '0;
      addr_r      <= '0;
      data_r      <= '0;
      len_r       <= '0;
      frame_tog_r <= 1'b0;
    end
    else if (active && !cs_n)
    begin
      if (bit_cnt_r == '0)
      begin
        frame_tog_r <= !frame_tog_r;
        len_r       <= '0;
      end
      else if (byte_end && len_r != sei_pkg::LEN_WRITE)
      begin
        len_r <= len_r + 3'h1;
      end
      if (bit_cnt_r == sei_pkg::CNT_OP_END)
      begin
        op_r <= byte_in;
      end
      if (bit_cnt_r == sei_pkg::CNT_ADH_END || bit_cnt_r == sei_pkg::CNT_ADL_END)
      begin
        addr_r <= {addr_r[7:0], byte_in};
      end
      // Only the first data byte of a write is kept.
      if ((bit_cnt_r == sei_pkg::CNT_ADH_END && op_r == sei_pkg::OP_WRSR)
          || (bit_cnt_r == sei_pkg::CNT_DATA_END && len_r == sei_pkg::LEN_WDATA))
      begin
        data_r <= byte_in;
      end
    end
  end

  // Output pad: new bit after each falling edge, floated when deselected
  // or on hold. A mode 3 leading fall finds no output phase.
  always_ff @(negedge sck or posedge frame_rst)
  begin
    if (frame_rst)
    begin
      so_oe <= 1'b0;
      so    <= 1'b0;
    end
    else
    begin
      so_oe <= out_ph && active;
      so    <= tx_byte[~bit_cnt_r[2:0]];
    end
  end

endmodule
`default_nettype wire

// [core/sei_pkg.sv]
// Shared constants for the serial EEPROM pin interface: geometry, opcodes,
// status bit positions, reset values, bit-count landmarks and write timing.
// Assumes nothing of its surroundings; sei_eeprom and the bench refer to it by scope.
package sei_pkg;

  // Array geometry: one byte per location, sixteen address bits.
  localparam int          ADDR_W    = 16;
  localparam int          DATA_W    = 8;
  localparam int          MEM_DEPTH = 65536;

  // Command opcodes; the values are plain defaults of this design.
  localparam logic [7:0]  OP_WREN   = 8'h06;
  localparam logic [7:0]  OP_WRDI   = 8'h04;
  localparam logic [7:0]  OP_RDSR   = 8'h05;
  localparam logic [7:0]  OP_WRSR   = 8'h01;
  localparam logic [7:0]  OP_READ   = 8'h03;
  localparam logic [7:0]  OP_WRITE  = 8'h02;

  // Status byte layout and reset values.
  localparam int          ST_BUSY   = 0;
  localparam int          ST_WEL    = 1;
  localparam int          ST_BP_LO  = 2;
  localparam int          ST_PEN    = 7;
  localparam logic        PEN_RST   = 1'b0;
  localparam logic [1:0]  BP_RST    = 2'b00;

  // Block protect settings and the first protected address of the quarter and half settings.
  localparam logic [1:0]  BP_NONE   = 2'b00;
  localparam logic [1:0]  BP_QUART  = 2'b01;
  localparam logic [1:0]  BP_HALF   = 2'b10;
  localparam logic [15:0] QUART_BASE = 16'hc000;
  localparam logic [15:0] HALF_BASE  = 16'h8000;

  // Rising-edge bit counts at which a byte completes, or an output phase begins, within a frame.
  localparam logic [5:0]  CNT_OP_END   = 6'h07;
  localparam logic [5:0]  CNT_ADH_END  = 6'h0f;
  localparam logic [5:0]  CNT_ADL_END  = 6'h17;
  localparam logic [5:0]  CNT_DATA0    = 6'h18;
  localparam logic [5:0]  CNT_DATA_END = 6'h1f;
  localparam logic [5:0]  CNT_RDSR0    = 6'h08;

  // Completed-byte counts a command needs before it may execute, and the count held while a write's data byte arrives.
  localparam logic [2:0]  LEN_OP    = 3'h1;
  localparam logic [2:0]  LEN_WRSR  = 3'h2;
  localparam logic [2:0]  LEN_WDATA = 3'h3;
  localparam logic [2:0]  LEN_WRITE = 3'h4;

  // Self-timed write: longest time in microseconds, clock rate in MHz.
  localparam int          WRITE_TIME_US = 5000;
  localparam int          CLOCK_MHZ     = 125;
  localparam int          WRITE_CYCLES  = WRITE_TIME_US * CLOCK_MHZ;

  // Kind of nonvolatile write waiting for its timer to finish.
  typedef enum logic [1:0] {
    SEI_WK_NONE   = 2'b00,
    SEI_WK_ARRAY  = 2'b01,
    SEI_WK_STATUS = 2'b10
  } sei_wkind_t;

endpackage

// [core/sei_sync.sv]
// Two flip-flop level synchroniser, one lane per bit.
// Assumes each lane is a level or a quasi-static bit; arst is active high.
`timescale 1ns/1ns
`default_nettype none
module sei_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             arst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta_r;

  // Both stages take the reset constant, so no lane wakes up unknown.
  always_ff @(posedge clk or posedge arst)
  begin
    if (arst)
    begin
      meta_r <= RST_VAL;
      dout   <= RST_VAL;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule
`default_nettype wire

// [core/sei_wtimer.sv]
// Self-timed write cycle counter on the system clock.
// Assumes start is a one-cycle pulse; busy stands for CYCLES clock cycles.
`timescale 1ns/1ns
`default_nettype none
module sei_wtimer #(
  parameter int CYCLES = 625000
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  // Cycles left in the running write.
  logic [CW-1:0] cnt_r;

  // A start while busy is dropped; the caller never issues one then.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        busy  <= 1'b1;
        cnt_r <= CW'(CYCLES - 1);
      end
      else if (busy && cnt_r == '0)
      begin
        busy <= 1'b0;
        done <= 1'b1;
      end
      else if (busy)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// [tb/sei_eeprom_monitor.sv]
// Port checker for the serial EEPROM pin interface.
// Assumes it is bound into sei_eeprom with the design's WRITE_CYCLES.
`timescale 1ns/1ns
`default_nettype none
module sei_eeprom_monitor #(
  parameter int WRITE_CYCLES = 20
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic so,
  input  wire logic so_oe,
  input  wire logic write_busy
);
  int busy_cnt_r;  // Clocks the write timer has stood busy so far.

  // Length counter, so the busy time is checked exactly, not just bounded.
  always_ff @(posedge clock)
  begin
    if (!rst_n || !write_busy)
      busy_cnt_r <= 0;
    else
      busy_cnt_r <= busy_cnt_r + 1;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_oe_desel: assert property (cs_n |-> !so_oe)
    else $error("so_oe high while deselected");
  a_oe_fall: assert property ($fell(so_oe) |-> cs_n || !sck)
    else $error("so_oe dropped while selected");
  a_oe_rise: assert property ($rose(so_oe) |-> !sck && !cs_n)
    else $error("so_oe rose away from a falling sck");
  a_so_change: assert property ($changed(so) && !cs_n |-> !sck)
    else $error("so changed while sck high");
  a_busy_len: assert property ($fell(write_busy) |-> busy_cnt_r == WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_max: assert property (write_busy |-> busy_cnt_r < WRITE_CYCLES)
    else $error("write cycle overran");
  a_busy_hold: assert property ($rose(write_busy) |=> write_busy [*8])
    else $error("write cycle cut short");
  a_busy_start: assert property ($rose(write_busy) |-> cs_n && $past(cs_n, 2))
    else $error("write started inside a frame");

  c_write: cover property ($rose(write_busy));
  c_drive: cover property ($rose(so_oe));
  c_release: cover property ($fell(so_oe) && cs_n);
endmodule
`default_nettype wire

// [tb/sei_host.sv]
// Behavioural bus host that frames transfers in mode 0 or mode 3.
// Assumes the bench hands it a resolved copy of the device's output line.
`timescale 1ns/1ns
`default_nettype none
module sei_host (
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_line
);
  // Selected through reset; the clock stands still outside frames.
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b0;
  end

  // Deselect once after reset, so the device sees a clean start.
  task automatic arm();
    cs_n = 1'b1;
    #100;
  endtask

  // One frame, 32 ns half period; rx keeps the last eight bits taken.
  task automatic frame(input logic cpol, input logic [31:0] tx, input int nbits,
                       output logic [7:0] rx);
    rx = 8'h00;
    sck = cpol;  // Idle level settles while still deselected.
    #32;
    cs_n = 1'b0;
    #32;
    for (int i = nbits - 1; i >= 0; i--)
    begin
      sck = 1'b0;  // Data changes on the falling edge.
      si = tx[i];
      #32;
      sck = 1'b1;
      rx = {rx[6:0], so_line};
      #32;
    end
    if (!cpol)
      sck = 1'b0;
    #32;
    cs_n = 1'b1;
    si = ~si;  // A released line must not keep showing its last bit.
    #200;
  endtask
endmodule
`default_nettype wire

// [tb/tb_sei_eeprom.sv]
// Self-checking bench for sei_eeprom with a bus host model.
// Assumes the design package is compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_sei_eeprom;
  localparam int WCYC = 400;  // Short write so status reads fit inside it.
  logic       clock;
  logic       rst_n;
  logic       wp_n;
  logic       hold_n;
  wire logic  sck;
  wire logic  cs_n;
  wire logic  si;
  logic       so;
  logic       so_oe;
  logic       write_busy;
  wire logic  so_line;
  logic [7:0] st;
  int         err_count;
  int         check_count;

  assign so_line = so_oe ? so : 1'bz;  // Pad seen by the host.

  sei_eeprom #(.WRITE_CYCLES(WCYC)) i_sei_eeprom (.clock(clock), .rst_n(rst_n),
    .sck(sck), .cs_n(cs_n), .si(si), .wp_n(wp_n), .hold_n(hold_n), .so(so),
    .so_oe(so_oe), .write_busy(write_busy));
  sei_host i_sei_host (.sck(sck), .cs_n(cs_n), .si(si), .so_line(so_line));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Bounded wait for the write timer to reach a level.
  task automatic wait_busy(input logic lvl, input int bound);
    int n;
    n = 0;
    while (write_busy !== lvl && n < bound)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check({7'h00, write_busy}, {7'h00, lvl});
    if (write_busy !== lvl)
      summarize();
  endtask

  task automatic cmd(input logic [7:0] op);
    i_sei_host.frame(1'b0, {24'h000000, op}, 8, st);
  endtask

  task automatic rdsr(input logic cpol);
    i_sei_host.frame(cpol, {24'h000000, sei_pkg::OP_RDSR, 8'h00}, 16, st);
  endtask

  task automatic wrsr(input logic [7:0] val);
    cmd(sei_pkg::OP_WREN);
    i_sei_host.frame(1'b0, {16'h0000, sei_pkg::OP_WRSR, val}, 16, st);
  endtask

  task automatic t_select();
    check({7'h00, so_line}, {7'h00, 1'bz});
    rdsr(1'b0);
    check(st, 8'h00);
    $display("t_select done");
  endtask

  // Latch set and cleared, read back in both clock polarities.
  task automatic t_modes();
    for (int m = 0; m < 2; m++)
    begin
      cmd(sei_pkg::OP_WREN);
      rdsr(m[0]);
      check(st, 8'h02);
      cmd(sei_pkg::OP_WRDI);
      rdsr(m[0]);
      check(st, 8'h00);
    end
    $display("t_modes done");
  endtask

  // Hold low across a whole frame: output floats; only the first two edges count, before the hold crosses on sck.
  task automatic t_hold();
    @(posedge clock);
    hold_n <= 1'b0;
    rdsr(1'b0);
    check(st, 8'hzz);
    @(posedge clock);
    hold_n <= 1'b1;
    cmd(8'h00);  // Idle frame lets the hold release cross on sck.
    rdsr(1'b0);
    check(st, 8'h00);
    $display("t_hold done");
  endtask

  // Both ends of the address range, written in mode 0 and read back in mode 3.
  task automatic t_array();
    logic [15:0] adr;
    logic [7:0]  dat;
    for (int i = 0; i < 2; i++)
    begin
      adr = i ? 16'hffff : 16'h0000;
      dat = i ? 8'ha5 : 8'h5a;
      cmd(sei_pkg::OP_WREN);
      i_sei_host.frame(1'b0, {sei_pkg::OP_WRITE, adr, dat}, 32, st);
      wait_busy(1'b1, 20);
      rdsr(1'b1);
      check(st, 8'h03);
      wait_busy(1'b0, WCYC);
      i_sei_host.frame(1'b1, {sei_pkg::OP_READ, adr, 8'h00}, 32, st);
      check(st, dat);
    end
    $display("t_array done");
  endtask

  task automatic t_protect();
    wrsr(8'h8c);
    wait_busy(1'b1, 20);
    @(posedge clock);
    wp_n <= 1'b0;
    wait_busy(1'b0, WCYC);
    rdsr(1'b0);
    check(st, 8'h8c);
    wrsr(8'h00);
    check({7'h00, write_busy}, 8'h00);
    @(posedge clock);
    wp_n <= 1'b1;
    i_sei_host.frame(1'b0, {sei_pkg::OP_WRITE, 16'hffff, 8'h3c}, 32, st);
    check({7'h00, write_busy}, 8'h00);
    i_sei_host.frame(1'b0, {sei_pkg::OP_READ, 16'hffff, 8'h00}, 32, st);
    check(st, 8'ha5);
    fork
      i_sei_host.frame(1'b0, {16'h0000, sei_pkg::OP_WRSR, 8'h00}, 16, st);
      begin
        repeat (60) @(posedge clock);
        wp_n <= 1'b0;
        repeat (20) @(posedge clock);
        wp_n <= 1'b1;
      end
    join
    rdsr(1'b0);
    check(st, 8'h8e);
    wrsr(8'h00);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, WCYC);
    @(posedge clock);
    wp_n <= 1'b0;
    wrsr(8'h04);
    wait_busy(1'b1, 20);
    wait_busy(1'b0, WCYC);
    rdsr(1'b0);
    check(st, 8'h04);
    $display("t_protect done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    hold_n = 1'b1;
    err_count = 0;
    check_count = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    i_sei_host.arm();
    t_select();
    t_modes();
    t_hold();
    t_array();
    t_protect();
    summarize();
  end
endmodule

bind sei_eeprom sei_eeprom_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) i_sei_eeprom_monitor (
  .clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .so(so), .so_oe(so_oe),
  .write_busy(write_busy));
`default_nettype wire
